// ### rtl/hbcc_driver.sv
/*
 * Bridge driver end: decodes the control pins into bridge output states
 * and runs the fixed off-time current chopper with sense blanking.
 * Assumes the analog front end supplies synchronous comparator levels
 * and that the variant straps are static while out of reset.
 */
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Sleep low: outputs Hi-Z, regulators off
// - Enable high: direction picks forward or reverse
// - Enable low full-bridge: both outputs low
// - PWM inputs both low: coast, regulators on
// - PWM 01 reverse, 10 forward
// - Controller holds direction low for half-bridge
// - Half-bridge enable drives output B high/low
// - Controller never sets enable and direction together in half-bridge
// - PWM half-bridge: 00 coast, 01 B high
// - PWM half-bridge both high: B low
// - Controller never applies PWM 10 half-bridge
// - Threshold crossing forces brake for off-time
// - Off-time is 25 microseconds
// - Comparator ignored during blanking after drive starts
// - Trigger is amplified sense versus reference
// - Tie reference high, ground sense to disable
// - Grounded sense inputs disable chopping
// - Sense voltage above one volt flags overcurrent
// - Commanded brake is not a chopping event
module hbcc_driver #(
   parameter int OFF_CYC = hbcc_pkg::CHOP_OFF_CYC,
   parameter int BLANK_LEN = hbcc_pkg::BLANK_CYC
) (
   input wire logic clk,
   input wire logic srst,
   hbcc_if.driver ctl,
   input wire logic variant_pwm,
   input wire logic half_bridge,
   input wire logic chop_compare,
   input wire logic sense_grounded,
   input wire logic sense_over_volt,
   output logic bridge_output_a,
   output logic bridge_output_a_oe,
   output logic bridge_output_b,
   output logic bridge_output_b_oe,
   output logic regulators_on,
   output logic chop_active
);
   import hbcc_pkg::*;

   localparam logic [TIMER_W-1:0] OFF_LAST = TIMER_W'(OFF_CYC - 1);
   localparam logic [TIMER_W-1:0] BLANK_LAST = TIMER_W'(BLANK_LEN - 1);

   // ************************************************************
   // Command decode
   // ************************************************************
   hbcc_cmd_e cmd;
   hbcc_cmd_e prev_cmd;
   hbcc_cmd_e eff_cmd;
   hbcc_chop_e chop;
   logic [TIMER_W-1:0] timer;
   logic drive;
   logic drive_start;
   logic trip;

   // In half-bridge use the single output B follows the reverse
   // pattern, so driving high is decoded as reverse and A is left off.
   always_comb
   begin
      cmd = HBCC_COAST;
      if (!ctl.sleep_bar_input)
      begin
         cmd = HBCC_SLEEP;
      end
      else if (variant_pwm == MODE_DIR_EN)
      begin
         if (!ctl.enable_input)
         begin
            cmd = HBCC_BRAKE;
         end
         else if (half_bridge)
         begin
            // The forbidden combination falls back to coast.
            if (!ctl.direction_select)
            begin
               cmd = HBCC_REVERSE;
            end
         end
         else if (ctl.direction_select)
         begin
            cmd = HBCC_FORWARD;
         end
         else
         begin
            cmd = HBCC_REVERSE;
         end
      end
      else
      begin
         case ({ctl.bridge_input_a, ctl.bridge_input_b})
            2'b00: cmd = HBCC_COAST;
            2'b01: cmd = HBCC_REVERSE;
            2'b10: cmd = half_bridge ? HBCC_COAST : HBCC_FORWARD;
            2'b11: cmd = HBCC_BRAKE;
            default: cmd = HBCC_COAST;
         endcase
      end
   end

   assign drive = (cmd == HBCC_FORWARD) || (cmd == HBCC_REVERSE);
   // A new drive command, including a direction reversal, restarts blanking.
   assign drive_start = drive && (cmd != prev_cmd);

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         prev_cmd <= HBCC_SLEEP;
      end
      else
      begin
         prev_cmd <= cmd;
      end
   end

   // ************************************************************
   // Current chopper
   // ************************************************************
   // Grounded sense inputs mean the amplifier is off, so the comparator
   // is never trusted and the bridge is never forced into brake.
   assign trip = chop_compare && !sense_grounded;

   // Only forward or reverse drive can enter the chopper, so a brake
   // from the pins never counts as chopping.
   always_ff @(posedge clk)
   begin
      if (srst || !drive)
      begin
         chop <= CHOP_IDLE;
         timer <= TIMER_ZERO;
      end
      else if (drive_start)
      begin
         chop <= CHOP_BLANK;
         timer <= TIMER_ZERO;
      end
      else
      begin
         case (chop)
            CHOP_BLANK:
            begin
               if (timer == BLANK_LAST)
               begin
                  chop <= CHOP_SENSE;
                  timer <= TIMER_ZERO;
               end
               else
               begin
                  timer <= timer + TIMER_ONE;
               end
            end
            CHOP_SENSE:
            begin
               if (trip)
               begin
                  chop <= CHOP_OFF;
                  timer <= TIMER_ZERO;
               end
            end
            CHOP_OFF:
            begin
               // Drive current restarts here, so blanking starts again.
               if (timer == OFF_LAST)
               begin
                  chop <= CHOP_BLANK;
                  timer <= TIMER_ZERO;
               end
               else
               begin
                  timer <= timer + TIMER_ONE;
               end
            end
            default:
            begin
               chop <= CHOP_BLANK;
               timer <= TIMER_ZERO;
            end
         endcase
      end
   end

   always_comb
   begin
      eff_cmd = cmd;
      if (drive && (chop == CHOP_OFF))
      begin
         eff_cmd = HBCC_BRAKE;
      end
   end

   // ************************************************************
   // Output stage
   // ************************************************************
   // The outputs follow the pins one cycle later; the analog dead time
   // between high-side and low-side is outside this logic.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         bridge_output_a <= 1'b0;
         bridge_output_a_oe <= 1'b0;
         bridge_output_b <= 1'b0;
         bridge_output_b_oe <= 1'b0;
         regulators_on <= 1'b0;
         chop_active <= 1'b0;
      end
      else
      begin
         regulators_on <= (eff_cmd != HBCC_SLEEP);
         chop_active <= drive && (chop == CHOP_OFF);
         case (eff_cmd)
            HBCC_FORWARD:
            begin
               bridge_output_a <= 1'b1;
               bridge_output_b <= 1'b0;
               bridge_output_a_oe <= !half_bridge;
               bridge_output_b_oe <= 1'b1;
            end
            HBCC_REVERSE:
            begin
               bridge_output_a <= 1'b0;
               bridge_output_b <= 1'b1;
               bridge_output_a_oe <= !half_bridge;
               bridge_output_b_oe <= 1'b1;
            end
            HBCC_BRAKE:
            begin
               bridge_output_a <= 1'b0;
               bridge_output_b <= 1'b0;
               bridge_output_a_oe <= !half_bridge;
               bridge_output_b_oe <= 1'b1;
            end
            default:
            begin
               bridge_output_a <= 1'b0;
               bridge_output_b <= 1'b0;
               bridge_output_a_oe <= 1'b0;
               bridge_output_b_oe <= 1'b0;
            end
         endcase
      end
   end

   // ************************************************************
   // Overcurrent flag
   // ************************************************************
   // A level that follows the comparator; retry and deglitch belong
   // to the fault handling outside this block.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctl.overcurrent_trip <= 1'b0;
      end
      else
      begin
         ctl.overcurrent_trip <= sense_over_volt;
      end
   end

endmodule // hbcc_driver

`default_nettype wire

// ### rtl/hbcc_pkg.sv
/*
 * Shared constants and types for the H-bridge control and chopper logic:
 * bridge commands, chopper states and timing counts.
 * Assumes a single 125 MHz clock shared by both ends.
 */
package hbcc_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int CHOP_OFF_TIME_NS = 25000;
   localparam int SENSE_BLANK_WINDOW_NS = 2000;
   // Least times, so both round up to whole cycles.
   localparam int CHOP_OFF_CYC =
      (CHOP_OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_CYC =
      (SENSE_BLANK_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W = 12;
   localparam logic [TIMER_W-1:0] TIMER_ZERO = 12'h000;
   localparam logic [TIMER_W-1:0] TIMER_ONE = 12'h001;

   // ************************************************************
   // Interface variants
   // ************************************************************
   localparam logic MODE_DIR_EN = 1'b0;
   localparam logic MODE_PWM = 1'b1;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {
      HBCC_SLEEP = 3'b000,
      HBCC_COAST = 3'b001,
      HBCC_FORWARD = 3'b010,
      HBCC_REVERSE = 3'b011,
      HBCC_BRAKE = 3'b100
   } hbcc_cmd_e;

   typedef enum logic [1:0] {
      CHOP_IDLE = 2'b00,
      CHOP_BLANK = 2'b01,
      CHOP_SENSE = 2'b10,
      CHOP_OFF = 2'b11
   } hbcc_chop_e;

endpackage

// ### rtl/hbcc_if.sv
/*
 * Control pins between the system controller and the bridge driver.
 * Assumes both ends run on the same clock; the bench supplies it.
 */
`timescale 1ns/100ps
`default_nettype none

interface hbcc_if;
   logic sleep_bar_input;
   logic direction_select;
   logic enable_input;
   logic bridge_input_a;
   logic bridge_input_b;
   logic overcurrent_trip;

   modport driver (
      input sleep_bar_input,
      input direction_select,
      input enable_input,
      input bridge_input_a,
      input bridge_input_b,
      output overcurrent_trip
   );

   modport controller (
      output sleep_bar_input,
      output direction_select,
      output enable_input,
      output bridge_input_a,
      output bridge_input_b,
      input overcurrent_trip
   );
endinterface

`default_nettype wire

// ### rtl/hbcc_controller.sv
/*
 * Controller end: turns a requested bridge state into the control pins
 * of the chosen variant and refuses combinations that are forbidden.
 * Assumes the variant straps match those given to the driver end.
 */
`timescale 1ns/100ps
`default_nettype none

module hbcc_controller (
   input wire logic clk,
   input wire logic srst,
   hbcc_if.controller ctl,
   input wire logic variant_pwm,
   input wire logic half_bridge,
   input wire logic req_valid,
   input wire hbcc_pkg::hbcc_cmd_e req_cmd,
   output logic req_refused,
   output logic fault_seen
);
   import hbcc_pkg::*;

   logic legal;

   // Half-bridge use has no forward drive; asking for it is refused.
   assign legal = !(half_bridge && (req_cmd == HBCC_FORWARD));

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctl.sleep_bar_input <= 1'b0;
         ctl.direction_select <= 1'b0;
         ctl.enable_input <= 1'b0;
         ctl.bridge_input_a <= 1'b0;
         ctl.bridge_input_b <= 1'b0;
      end
      else if (req_valid && legal)
      begin
         ctl.sleep_bar_input <= (req_cmd != HBCC_SLEEP);
         if (variant_pwm == MODE_DIR_EN)
         begin
            // Coast does not exist here; it maps to brake.
            ctl.enable_input <= (req_cmd == HBCC_FORWARD) ||
                                (req_cmd == HBCC_REVERSE);
            ctl.direction_select <= !half_bridge &&
                                    (req_cmd == HBCC_FORWARD);
         end
         else
         begin
            ctl.bridge_input_a <= (req_cmd == HBCC_FORWARD) ||
                                  (req_cmd == HBCC_BRAKE);
            ctl.bridge_input_b <= (req_cmd == HBCC_REVERSE) ||
                                  (req_cmd == HBCC_BRAKE);
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         req_refused <= 1'b0;
         fault_seen <= 1'b0;
      end
      else
      begin
         req_refused <= req_valid && !legal;
         fault_seen <= ctl.overcurrent_trip;
      end
   end

endmodule // hbcc_controller

`default_nettype wire

// ### verification/hbcc_chk.sv
/* Checker for the bridge pins and the driver outputs.
   Assumes the bench instantiates it beside the interface, with BLANK_LEN 4. */
`timescale 1ns/100ps
`default_nettype none
module hbcc_chk #(
   parameter int OFF_CYC = 20
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic sleep_bar_input,
   input wire logic direction_select,
   input wire logic enable_input,
   input wire logic bridge_input_a,
   input wire logic bridge_input_b,
   input wire logic overcurrent_trip,
   input wire logic variant_pwm,
   input wire logic half_bridge,
   input wire logic sense_grounded,
   input wire logic sense_over_volt,
   input wire logic bridge_output_a,
   input wire logic bridge_output_a_oe,
   input wire logic bridge_output_b,
   input wire logic bridge_output_b_oe,
   input wire logic regulators_on,
   input wire logic chop_active,
   input wire logic fault_seen
);
   // ****
   // Helpers
   // ****
   logic fwd, rev, brk;
   logic [7:0] cnt;
   assign fwd = bridge_output_a_oe && bridge_output_a && bridge_output_b_oe
      && !bridge_output_b;
   assign rev = bridge_output_a_oe && !bridge_output_a && bridge_output_b_oe
      && bridge_output_b;
   assign brk = bridge_output_a_oe && !bridge_output_a && bridge_output_b_oe
      && !bridge_output_b;
   always_ff @(posedge clk)
   begin
      if (srst || !chop_active)
         cnt <= 8'h00;
      else
         cnt <= cnt + 8'h01;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence drive_start;
      $rose(fwd || rev);
   endsequence
   // The blank length 4 matches the driver instance of the bench.
   a_blank_hold:
   assert property (drive_start |-> !chop_active [*4])
      else $error("chop in blank");
   a_sleep_hiz:
   assert property (!sleep_bar_input |=> !bridge_output_a_oe
      && !bridge_output_b_oe && !regulators_on) else $error("sleep not idle");
   a_cmd_brake:
   assert property (sleep_bar_input && !half_bridge && (variant_pwm ?
      bridge_input_a && bridge_input_b : !enable_input) |=> brk
      && !chop_active) else $error("brake wrong");
   a_pwm_drive:
   assert property (sleep_bar_input && variant_pwm && !half_bridge
      && (bridge_input_a ^ bridge_input_b) |=> chop_active
      || ($past(bridge_input_a) ? fwd : rev)) else $error("pwm drive wrong");
   a_chop_brake:
   assert property (chop_active |-> bridge_output_b_oe && !bridge_output_b
      && !(bridge_output_a_oe && bridge_output_a))
      else $error("chop no brake");
   a_chop_cause:
   assert property ($rose(chop_active) |-> $past(fwd || rev
      || (half_bridge && bridge_output_b_oe && bridge_output_b)))
      else $error("chop without drive");
   a_off_time:
   assert property ($fell(chop_active) && !$past(srst) |-> cnt == 8'(OFF_CYC))
      else $error("off time wrong");
   a_grounded:
   assert property (sense_grounded |=> !$rose(chop_active))
      else $error("chop while grounded");
   a_trip_follow:
   assert property (sense_over_volt |=> overcurrent_trip ##1 fault_seen)
      else $error("trip not seen");
endmodule // hbcc_chk
`default_nettype wire

// ### verification/tb_top.sv
/* Self-checking bench: controller and driver joined by the interface.
   Assumes shortened chopper counts; the bench plays the sense front end. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import hbcc_pkg::*;
   typedef struct {
      logic pwm;
      logic half;
      hbcc_cmd_e cmd;
      logic [4:0] exp;
   } hbcc_row_s;
   localparam int OFF = 20;
   localparam int BL = 4;
   logic clk, srst, pwm, half, req_valid, cmp, gnd, sov, seen;
   logic req_refused, fault_seen, oa, oa_oe, ob, ob_oe, reg_on, chop;
   logic [4:0] obs;
   hbcc_cmd_e req_cmd;
   int failures, compares, n, k;
   // Expected {regulators, oe_a, a, oe_b, b}, levels masked by enable.
   hbcc_row_s rows [15] = '{'{0,0,HBCC_FORWARD,5'h1E},
      '{0,0,HBCC_REVERSE,5'h1B}, '{0,0,HBCC_BRAKE,5'h1A},
      '{0,0,HBCC_COAST,5'h1A}, '{0,0,HBCC_SLEEP,5'h00},
      '{1,0,HBCC_FORWARD,5'h1E}, '{1,0,HBCC_REVERSE,5'h1B},
      '{1,0,HBCC_BRAKE,5'h1A}, '{1,0,HBCC_COAST,5'h10},
      '{1,0,HBCC_SLEEP,5'h00}, '{0,1,HBCC_REVERSE,5'h13},
      '{0,1,HBCC_BRAKE,5'h12}, '{1,1,HBCC_COAST,5'h10},
      '{1,1,HBCC_REVERSE,5'h13}, '{1,1,HBCC_BRAKE,5'h12}};
   assign obs = {reg_on, oa_oe, oa & oa_oe, ob_oe, ob & ob_oe};
   hbcc_if bus ();
   hbcc_controller hbcc_controller_inst (.clk(clk), .srst(srst), .ctl(bus),
      .variant_pwm(pwm), .half_bridge(half), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_refused(req_refused), .fault_seen(fault_seen));
   hbcc_driver #(.OFF_CYC(OFF), .BLANK_LEN(BL)) hbcc_driver_inst (.clk(clk),
      .srst(srst), .ctl(bus), .variant_pwm(pwm), .half_bridge(half),
      .chop_compare(cmp), .sense_grounded(gnd), .sense_over_volt(sov),
      .bridge_output_a(oa), .bridge_output_a_oe(oa_oe), .bridge_output_b(ob),
      .bridge_output_b_oe(ob_oe), .regulators_on(reg_on), .chop_active(chop));
   hbcc_chk #(.OFF_CYC(OFF)) hbcc_chk_inst (.clk(clk), .srst(srst),
      .sleep_bar_input(bus.sleep_bar_input),
      .direction_select(bus.direction_select),
      .enable_input(bus.enable_input), .bridge_input_a(bus.bridge_input_a),
      .bridge_input_b(bus.bridge_input_b),
      .overcurrent_trip(bus.overcurrent_trip), .variant_pwm(pwm),
      .half_bridge(half), .sense_grounded(gnd), .sense_over_volt(sov),
      .bridge_output_a(oa), .bridge_output_a_oe(oa_oe), .bridge_output_b(ob),
      .bridge_output_b_oe(ob_oe), .regulators_on(reg_on), .chop_active(chop),
      .fault_seen(fault_seen));
   // ****
   // Tasks
   // ****
   task automatic chk(input logic [4:0] got, input logic [4:0] exp);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic rst(input int cyc);
      srst = 1'b1;
      repeat (cyc) @(negedge clk);
      srst = 1'b0;
   endtask
   // Request stays up for one edge; the caller lowers it after the last one.
   task automatic req(input hbcc_cmd_e c);
      req_cmd = c;
      req_valid = 1'b1;
      @(negedge clk);
   endtask
   // ****
   // Sequence
   // ****
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      #100000;
      failures++;
      summarize();
   end
   initial
   begin
      {pwm, half, req_valid, cmp, gnd, sov} = 6'h00;
      req_cmd = HBCC_SLEEP;
      failures = 0;
      compares = 0;
      rst(20);
      chk(obs, 5'h00);
      $display("test reset done");
      foreach (rows[i])
      begin
         pwm = rows[i].pwm;
         half = rows[i].half;
         rst(1);
         req(rows[i].cmd);
         req_valid = 1'b0;
         repeat (2) @(negedge clk);
         chk(obs, rows[i].exp);
      end
      $display("test table done");
      half = 1'b1;
      for (n = 0; n < 2; n++)
      begin
         pwm = n[0];
         rst(1);
         req(HBCC_REVERSE);
         req(HBCC_FORWARD);
         req_valid = 1'b0;
         chk({4'h0, req_refused}, 5'h01);
         repeat (2) @(negedge clk);
         chk(obs, 5'h13);
      end
      $display("test refusal done");
      {pwm, half, cmp} = 3'h5;
      rst(1);
      req(HBCC_FORWARD);
      req_valid = 1'b0;
      for (k = 1; k < 30 && chop !== 1'b1; k++)
         @(negedge clk);
      chk({4'h0, k > BL + 1 && k < BL + 6}, 5'h01);
      chk(obs, 5'h1A);
      for (k = 0; k < 99 && chop === 1'b1; k++)
         @(negedge clk);
      chk(k[4:0], 5'h14);
      chk(obs, 5'h1E);
      $display("test chopper done");
      for (n = 0; n < 2; n++)
      begin
         gnd = n[0];
         rst(1);
         req(n ? HBCC_FORWARD : HBCC_BRAKE);
         req_valid = 1'b0;
         seen = 1'b0;
         repeat (3 * OFF) @(negedge clk) seen |= chop;
         chk({4'h0, seen}, 5'h00);
      end
      {cmp, gnd, sov} = 3'h1;
      @(negedge clk);
      chk({3'h0, bus.overcurrent_trip, fault_seen}, 5'h02);
      @(negedge clk);
      chk({3'h0, bus.overcurrent_trip, fault_seen}, 5'h03);
      sov = 1'b0;
      $display("test sense done");
      summarize();
   end
endmodule // tb_top
`default_nettype wire
